// >>> design/bte_consts.svh
`ifndef BTE_CONSTS_SVH
`define BTE_CONSTS_SVH

// ==================================================
// register byte addresses
`define BTE_CTRL0_ADDR 8'h90
`define BTE_CTRL1_ADDR 8'h91
`define BTE_DEPTH_ADDR 8'h92
`define BTE_SA_BASE_ADDR 8'h93
`define BTE_SA_WIDTH_ADDR 8'h97
`define BTE_SA_LEFT_ADDR 8'h99
`define BTE_SA_TOP_ADDR 8'h9B
`define BTE_SB_BASE_ADDR 8'h9D
`define BTE_SB_WIDTH_ADDR 8'hA1
`define BTE_SB_LEFT_ADDR 8'hA3
`define BTE_SB_TOP_ADDR 8'hA5
`define BTE_TG_BASE_ADDR 8'hA7
`define BTE_TG_WIDTH_ADDR 8'hAB
`define BTE_TG_LEFT_ADDR 8'hAD
`define BTE_TG_TOP_ADDR 8'hAF
`define BTE_OPW_ADDR 8'hB1
`define BTE_OPH_ADDR 8'hB3
`define BTE_BLEND_ADDR 8'hB5
`define BTE_REG_COUNT 38
`define BTE_REG_RESET 8'h00

// ==================================================
// field positions
`define BTE_ENABLE_BIT 4
`define BTE_PATTERN_BIT 0
`define BTE_OPCODE_LSB 0
`define BTE_SA_DEPTH_LSB 5
`define BTE_SB_DEPTH_LSB 2
`define BTE_TG_DEPTH_LSB 0

// ==================================================
// write masks for bytes with fixed or unused bits
`define BTE_MASK_CTRL0 8'h01
`define BTE_MASK_DEPTH 8'h7F
`define BTE_MASK_ALIGN 8'hFC
`define BTE_MASK_HIGH13 8'h1F
`define BTE_MASK_BLEND 8'h3F
`define BTE_MASK_FULL 8'hFF

// ==================================================
// pattern sizes in pixels
`define BTE_PATTERN_SMALL 13'h0008
`define BTE_PATTERN_LARGE 13'h0010

`endif

// >>> design/bte_pkg.sv
package bte_pkg;

    typedef enum logic [3:0] {
        BTE_OP_PAT_ROP = 4'h6,
        BTE_OP_PAT_KEY = 4'h7,
        BTE_OP_HOST_BLEND = 4'hB,
        BTE_OP_SOLID_FILL = 4'hC,
        BTE_OP_RESERVED = 4'hD,
        BTE_OP_MONO_EXPAND = 4'hE,
        BTE_OP_MONO_KEY = 4'hF
    } bte_opcode_type;

    typedef enum logic [2:0] {
        BTE_SB_8BPP = 3'h0,
        BTE_SB_16BPP = 3'h1,
        BTE_SB_24BPP = 3'h2,
        BTE_SB_CONST = 3'h3,
        BTE_SB_ALPHA8 = 3'h4,
        BTE_SB_ALPHA16 = 3'h5
    } bte_sb_depth_type;

    typedef enum {
        BTE_IDLE,
        BTE_PIX_START,
        BTE_HOST_WAIT,
        BTE_READ_A,
        BTE_READ_B,
        BTE_BLEND,
        BTE_WRITE,
        BTE_WRITE_WAIT,
        BTE_NEXT
    } bte_fsm_type;

    typedef struct packed {
        logic [37:0][7:0] regs;
        bte_fsm_type st;
        logic [12:0] x;
        logic [12:0] y;
        logic [23:0] pix_a;
        logic [23:0] pix_b;
        logic mem_req;
        logic mem_we;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
        logic host_ready;
        logic [7:0] rdata;
        logic busy;
    } bte_state_type;

endpackage : bte_pkg

// >>> design/bte_blend_if.sv
`timescale 1ns/1ps
interface bte_blend_if;
    logic [23:0] pix_a;
    logic [23:0] pix_b;
    logic [5:0] factor;
    logic [23:0] mixed;

    modport core (output pix_a, output pix_b, output factor, input mixed);
    modport mixer (input pix_a, input pix_b, input factor, output mixed);
endinterface : bte_blend_if

// >>> design/bte_blend.sv
`timescale 1ns/1ps
module bte_blend (
    // blend operands and result
    bte_blend_if.mixer bl
);
    logic [5:0] alpha;

    // ==================================================
    // factor decode: 00h..1Fh is n/32, 2Xh is exactly one
    assign alpha = bl.factor[5] ? 6'h20 : {1'b0, bl.factor[4:0]};

    genvar c;
    generate
        for (c = 0; c < 3; c++) begin : g_comp
            logic [13:0] sum;
            // a*(1-alpha) + b*alpha per component
            assign sum = 14'(bl.pix_a[c*8 +: 8] * (6'h20 - alpha)) + 14'(bl.pix_b[c*8 +: 8] * alpha);
            assign bl.mixed[c*8 +: 8] = sum[12:5];
        end
    endgenerate
endmodule : bte_blend

// >>> design/bte_setup.sv
// Contract
// - opcode 1011b: host source A blended with memory source B, written to target
// - opcode 1100b: fill target window with register colour, no source read
// - opcode 1110b: expand monochrome source A bits from memory into colour pixels
// - opcode 1111b: zero bit leaves target untouched, one bit writes foreground
// - source A and target depth: 00b 8bpp, 01b 16bpp, 1x 24bpp
// - source B depth: 8, 16, 24 bpp, constant colour, 8 or 16 bit alpha
// - constant colour mode: base bytes become red, green, blue; top byte ignored
// - all three base addresses are word aligned, low two bits zero
// - window corner coordinates are 13 bits over two bytes, top three bits unused
// - operation window width and height are 13-bit counts over two bytes
// - pattern fill uses 8 or 16 pixel window, ignoring programmed size
// - blend factor 00h..1Fh means n/32, 2Xh means one
// - output equals A times one minus alpha plus B times alpha
// - writing enable bit 4 starts the engine, reading it returns busy
// - opcode is the low four bits of the second control register
`timescale 1ns/1ps
`include "bte_consts.svh"
module bte_setup
    import bte_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    // colours from the rest of the unit
    input wire logic [23:0] fg_color_i,
    input wire logic [23:0] bg_color_i,
    // host pixel stream for source A
    input wire logic [23:0] host_pix_i,
    input wire logic host_pix_valid_i,
    output logic host_pix_ready_o,
    // display memory port
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [31:0] mem_addr_o,
    output logic [31:0] mem_wdata_o,
    input wire logic [31:0] mem_rdata_i,
    input wire logic mem_ack_i,
    // status
    output logic busy_o
);

    bte_state_type q;
    bte_state_type d;
    bte_blend_if bl ();

    // ==================================================
    // register field views
    logic [7:0] reg_idx;
    logic in_range;
    logic pattern_large;
    bte_opcode_type opcode;
    logic [1:0] sa_depth;
    bte_sb_depth_type sb_depth;
    logic [1:0] tg_depth;
    logic [31:0] sa_base;
    logic [31:0] sb_base;
    logic [31:0] tg_base;
    logic [12:0] sa_width;
    logic [12:0] sa_left;
    logic [12:0] sa_top;
    logic [12:0] sb_width;
    logic [12:0] sb_left;
    logic [12:0] sb_top;
    logic [12:0] tg_width;
    logic [12:0] tg_left;
    logic [12:0] tg_top;
    logic [12:0] op_window_width;
    logic [12:0] op_window_height;
    logic [12:0] eff_width;
    logic [12:0] eff_height;
    logic [23:0] const_color;
    logic is_pattern;
    logic mono_bit;
    logic start;

    function automatic logic [12:0] pair13(input logic [37:0][7:0] r, input logic [7:0] addr);
        logic [7:0] i;
        i = addr - `BTE_CTRL0_ADDR;
        return {r[i + 8'h01][4:0], r[i]};
    endfunction : pair13

    function automatic logic [31:0] quad32(input logic [37:0][7:0] r, input logic [7:0] addr);
        logic [7:0] i;
        i = addr - `BTE_CTRL0_ADDR;
        return {r[i + 8'h03], r[i + 8'h02], r[i + 8'h01], r[i][7:2], 2'b00};
    endfunction : quad32

    always_comb begin
        reg_idx = reg_addr_i - `BTE_CTRL0_ADDR;
        in_range = (reg_addr_i >= `BTE_CTRL0_ADDR) && (reg_addr_i <= `BTE_BLEND_ADDR);
        pattern_large = q.regs[0][`BTE_PATTERN_BIT];
        opcode = bte_opcode_type'(q.regs[1][`BTE_OPCODE_LSB +: 4]);
        sa_depth = q.regs[2][`BTE_SA_DEPTH_LSB +: 2];
        sb_depth = bte_sb_depth_type'(q.regs[2][`BTE_SB_DEPTH_LSB +: 3]);
        tg_depth = q.regs[2][`BTE_TG_DEPTH_LSB +: 2];
        sa_base = quad32(q.regs, `BTE_SA_BASE_ADDR);
        sb_base = quad32(q.regs, `BTE_SB_BASE_ADDR);
        tg_base = quad32(q.regs, `BTE_TG_BASE_ADDR);
        sa_width = pair13(q.regs, `BTE_SA_WIDTH_ADDR);
        sa_left = pair13(q.regs, `BTE_SA_LEFT_ADDR);
        sa_top = pair13(q.regs, `BTE_SA_TOP_ADDR);
        sb_width = pair13(q.regs, `BTE_SB_WIDTH_ADDR);
        sb_left = pair13(q.regs, `BTE_SB_LEFT_ADDR);
        sb_top = pair13(q.regs, `BTE_SB_TOP_ADDR);
        tg_width = pair13(q.regs, `BTE_TG_WIDTH_ADDR);
        tg_left = pair13(q.regs, `BTE_TG_LEFT_ADDR);
        tg_top = pair13(q.regs, `BTE_TG_TOP_ADDR);
        op_window_width = pair13(q.regs, `BTE_OPW_ADDR);
        op_window_height = pair13(q.regs, `BTE_OPH_ADDR);
        // base bytes reread as {blue, green, red}, top byte dropped
        const_color = {q.regs[`BTE_SB_BASE_ADDR - `BTE_CTRL0_ADDR + 2],
                       q.regs[`BTE_SB_BASE_ADDR - `BTE_CTRL0_ADDR + 1],
                       q.regs[`BTE_SB_BASE_ADDR - `BTE_CTRL0_ADDR]};
        is_pattern = (opcode == BTE_OP_PAT_ROP) || (opcode == BTE_OP_PAT_KEY);
        if (is_pattern) begin
            eff_width = pattern_large ? `BTE_PATTERN_LARGE : `BTE_PATTERN_SMALL;
            eff_height = pattern_large ? `BTE_PATTERN_LARGE : `BTE_PATTERN_SMALL;
        end else begin
            eff_width = op_window_width;
            eff_height = op_window_height;
        end
    end

    // ==================================================
    // pixel format helpers; colour is kept as {blue, green, red}
    function automatic logic [31:0] bytes_per_pixel(input logic [2:0] code);
        case (code)
            3'h0, 3'h4: return 32'h1;
            3'h1, 3'h5: return 32'h2;
            default: return 32'h3;
        endcase
    endfunction : bytes_per_pixel

    function automatic logic [2:0] wide_code(input logic [1:0] code);
        return code[1] ? 3'h2 : {2'b00, code[0]};
    endfunction : wide_code

    function automatic logic [23:0] to_color(input logic [2:0] code, input logic [31:0] w);
        case (code)
            3'h0, 3'h4: return {{4{w[7:6]}}, w[5:3], w[5:3], w[5:4], w[2:0], w[2:0], w[2:1]};
            3'h1, 3'h5: return {w[15:11], w[15:13], w[10:5], w[10:9], w[4:0], w[4:2]};
            default: return w[23:0];
        endcase
    endfunction : to_color

    function automatic logic [31:0] from_color(input logic [2:0] code, input logic [23:0] c);
        case (code)
            3'h0: return {24'h000000, c[23:22], c[15:13], c[7:5]};
            3'h1: return {16'h0000, c[23:19], c[15:10], c[7:3]};
            default: return {8'h00, c};
        endcase
    endfunction : from_color

    function automatic logic [31:0] lin_index(input logic [12:0] width, input logic [12:0] left,
                                              input logic [12:0] top, input logic [12:0] x, input logic [12:0] y);
        logic [31:0] row;
        logic [31:0] col;
        row = 32'(top) + 32'(y);
        col = 32'(left) + 32'(x);
        return row * 32'(width) + col;
    endfunction : lin_index

    // ==================================================
    // blend datapath
    assign bl.pix_a = q.pix_a;
    assign bl.pix_b = q.pix_b;
    assign bl.factor = q.regs[`BTE_BLEND_ADDR - `BTE_CTRL0_ADDR][5:0];

    bte_blend u_blend (
        .bl(bl.mixer)
    );

    // ==================================================
    // next-state logic
    always_comb begin
        d = q;
        d.rdata = 8'h00;
        start = reg_we_i && (reg_addr_i == `BTE_CTRL0_ADDR) && reg_wdata_i[`BTE_ENABLE_BIT] && (q.st == BTE_IDLE);
        mono_bit = mem_rdata_i[3'h7 - q.x[2:0]];

        // register port; fixed and unused bits are never stored
        if (reg_we_i && in_range) begin
            case (reg_addr_i)
                `BTE_CTRL0_ADDR: d.regs[reg_idx] = reg_wdata_i & `BTE_MASK_CTRL0;
                `BTE_DEPTH_ADDR: d.regs[reg_idx] = reg_wdata_i & `BTE_MASK_DEPTH;
                `BTE_SA_BASE_ADDR, `BTE_SB_BASE_ADDR, `BTE_TG_BASE_ADDR,
                `BTE_SA_WIDTH_ADDR, `BTE_SB_WIDTH_ADDR, `BTE_TG_WIDTH_ADDR:
                    d.regs[reg_idx] = reg_wdata_i & `BTE_MASK_ALIGN;
                `BTE_SA_WIDTH_ADDR + 8'h01, `BTE_SA_LEFT_ADDR + 8'h01, `BTE_SA_TOP_ADDR + 8'h01,
                `BTE_SB_WIDTH_ADDR + 8'h01, `BTE_SB_LEFT_ADDR + 8'h01, `BTE_SB_TOP_ADDR + 8'h01,
                `BTE_TG_WIDTH_ADDR + 8'h01, `BTE_TG_LEFT_ADDR + 8'h01, `BTE_TG_TOP_ADDR + 8'h01,
                `BTE_OPW_ADDR + 8'h01, `BTE_OPH_ADDR + 8'h01:
                    d.regs[reg_idx] = reg_wdata_i & `BTE_MASK_HIGH13;
                `BTE_BLEND_ADDR: d.regs[reg_idx] = reg_wdata_i & `BTE_MASK_BLEND;
                default: d.regs[reg_idx] = reg_wdata_i & `BTE_MASK_FULL;
            endcase
        end
        if (reg_re_i && in_range) begin
            if (reg_addr_i == `BTE_CTRL0_ADDR) begin
                d.rdata = q.regs[0];
                d.rdata[`BTE_ENABLE_BIT] = q.busy;
            end else begin
                d.rdata = q.regs[reg_idx];
            end
        end

        // engine
        case (q.st)
            BTE_IDLE: begin
                // a zero width or height would wrap to 8192 pixels, so an empty window is not started
                if (start && (eff_width != 13'h0000) && (eff_height != 13'h0000)) begin
                    d.x = 13'h0000;
                    d.y = 13'h0000;
                    d.st = BTE_PIX_START;
                end
            end
            BTE_PIX_START: begin
                case (opcode)
                    BTE_OP_HOST_BLEND: begin
                        d.host_ready = 1'b1;
                        d.st = BTE_HOST_WAIT;
                    end
                    BTE_OP_SOLID_FILL: begin
                        d.pix_a = fg_color_i;
                        d.st = BTE_WRITE;
                    end
                    BTE_OP_MONO_EXPAND, BTE_OP_MONO_KEY: begin
                        d.mem_req = 1'b1;
                        d.mem_addr = sa_base + (lin_index(sa_width, sa_left, sa_top, q.x, q.y) >> 3);
                        d.st = BTE_READ_A;
                    end
                    BTE_OP_PAT_ROP, BTE_OP_PAT_KEY: begin
                        d.mem_req = 1'b1;
                        d.mem_addr = sa_base + lin_index(sa_width, sa_left, sa_top, q.x, q.y)
                                     * bytes_per_pixel(wide_code(sa_depth));
                        d.st = BTE_READ_A;
                    end
                    default: d.st = BTE_IDLE;
                endcase
            end
            BTE_HOST_WAIT: begin
                if (host_pix_valid_i && q.host_ready) begin
                    d.host_ready = 1'b0;
                    d.pix_a = host_pix_i;
                    if (sb_depth == BTE_SB_CONST) begin
                        d.pix_b = const_color;
                        d.st = BTE_BLEND;
                    end else begin
                        d.mem_req = 1'b1;
                        d.mem_addr = sb_base + lin_index(sb_width, sb_left, sb_top, q.x, q.y)
                                     * bytes_per_pixel(sb_depth);
                        d.st = BTE_READ_B;
                    end
                end
            end
            BTE_READ_A: begin
                if (mem_ack_i) begin
                    d.mem_req = 1'b0;
                    d.st = BTE_WRITE;
                    if (is_pattern) begin
                        d.pix_a = to_color(wide_code(sa_depth), mem_rdata_i);
                        if ((opcode == BTE_OP_PAT_KEY) && (d.pix_a == bg_color_i)) begin
                            d.st = BTE_NEXT;
                        end
                    end else begin
                        d.pix_a = mono_bit ? fg_color_i : bg_color_i;
                        if ((opcode == BTE_OP_MONO_KEY) && !mono_bit) begin
                            d.st = BTE_NEXT;
                        end
                    end
                end
            end
            BTE_READ_B: begin
                if (mem_ack_i) begin
                    d.mem_req = 1'b0;
                    d.pix_b = to_color(sb_depth, mem_rdata_i);
                    d.st = BTE_BLEND;
                end
            end
            BTE_BLEND: begin
                d.pix_a = bl.mixed;
                d.st = BTE_WRITE;
            end
            BTE_WRITE: begin
                d.mem_req = 1'b1;
                d.mem_we = 1'b1;
                d.mem_addr = tg_base + lin_index(tg_width, tg_left, tg_top, q.x, q.y)
                             * bytes_per_pixel(wide_code(tg_depth));
                d.mem_wdata = from_color(wide_code(tg_depth), q.pix_a);
                d.st = BTE_WRITE_WAIT;
            end
            BTE_WRITE_WAIT: begin
                if (mem_ack_i) begin
                    d.mem_req = 1'b0;
                    d.mem_we = 1'b0;
                    d.st = BTE_NEXT;
                end
            end
            BTE_NEXT: begin
                d.st = BTE_PIX_START;
                if (q.x == eff_width - 13'h0001) begin
                    d.x = 13'h0000;
                    if (q.y == eff_height - 13'h0001) begin
                        d.st = BTE_IDLE;
                    end else begin
                        d.y = q.y + 13'h0001;
                    end
                end else begin
                    d.x = q.x + 13'h0001;
                end
            end
            default: d.st = BTE_IDLE;
        endcase
        d.busy = (d.st != BTE_IDLE);
    end

    // ==================================================
    // state register
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q.regs <= {`BTE_REG_COUNT{`BTE_REG_RESET}};
            q.st <= BTE_IDLE;
            q.x <= 13'h0000;
            q.y <= 13'h0000;
            q.pix_a <= 24'h000000;
            q.pix_b <= 24'h000000;
            q.mem_req <= 1'b0;
            q.mem_we <= 1'b0;
            q.mem_addr <= 32'h00000000;
            q.mem_wdata <= 32'h00000000;
            q.host_ready <= 1'b0;
            q.rdata <= 8'h00;
            q.busy <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ==================================================
    // outputs, all straight from the state register
    assign reg_rdata_o = q.rdata;
    assign host_pix_ready_o = q.host_ready;
    assign mem_req_o = q.mem_req;
    assign mem_we_o = q.mem_we;
    assign mem_addr_o = q.mem_addr;
    assign mem_wdata_o = q.mem_wdata;
    assign busy_o = q.busy;

endmodule : bte_setup

// >>> dv/bte_mem_model.sv
`timescale 1ns/1ps
module bte_mem_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // display memory port
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    output logic [31:0] mem_rdata_o,
    output logic mem_ack_o,
    // bench control and record
    input wire logic [3:0] lat_i,
    input wire logic [7:0] rd_byte_i,
    output int n_wr_o,
    output logic [31:0] last_addr_o,
    output logic [31:0] last_data_o
);
    logic [3:0] cnt_q;
    // ==================================================
    // acknowledge
    // byte in every lane; data toggles outside an ack
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 32'h0;
            n_wr_o <= 0;
            last_addr_o <= 32'h0;
            last_data_o <= 32'h0;
        end else begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            if (mem_req_i && !mem_ack_o) begin
                cnt_q <= (cnt_q == lat_i) ? 4'h0 : cnt_q + 4'h1;
                if (cnt_q == lat_i) begin
                    mem_ack_o <= 1'b1;
                    mem_rdata_o <= {4{rd_byte_i}};
                    if (mem_we_i) begin
                        n_wr_o <= n_wr_o + 1;
                        last_addr_o <= mem_addr_i;
                        last_data_o <= mem_wdata_i;
                    end
                end
            end
        end
    end
endmodule : bte_mem_model

// >>> dv/bte_setup_asserts.sv
`timescale 1ns/1ps
module bte_setup_asserts (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_re_i,
    input wire logic [7:0] reg_rdata_o,
    // host stream, memory and status
    input wire logic host_pix_valid_i,
    input wire logic host_pix_ready_o,
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic [31:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic busy_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_read_done;
        reg_re_i ##1 !reg_re_i;
    endsequence
    sequence s_mem_wait;
        mem_req_o && !mem_ack_i;
    endsequence
    property p_busy_read;
        reg_re_i && reg_addr_i == 8'h90 |=> reg_rdata_o[7:1] == {3'b000, $past(busy_o), 3'b000};
    endproperty
    property p_depth_mask;
        reg_re_i && reg_addr_i == 8'h92 |=> !reg_rdata_o[7];
    endproperty
    property p_align;
        reg_re_i && reg_addr_i inside {8'h93, 8'h9D, 8'hA7} |=> reg_rdata_o[1:0] == 2'b00;
    endproperty
    property p_high13;
        reg_re_i && reg_addr_i inside {8'h98, 8'h9A, 8'h9C, 8'hA2, 8'hA4, 8'hA6, 8'hAC, 8'hAE, 8'hB0, 8'hB2, 8'hB4}
            |=> reg_rdata_o[7:5] == 3'b000;
    endproperty
    property p_blend_mask;
        reg_re_i && reg_addr_i == 8'hB5 |=> reg_rdata_o[7:6] == 2'b00;
    endproperty
    property p_rdata_drop;
        s_read_done |=> reg_rdata_o == 8'h00;
    endproperty
    property p_req_hold;
        s_mem_wait |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_wdata_o) && $stable(mem_we_o);
    endproperty
    property p_req_drop;
        mem_req_o && mem_ack_i |=> !mem_req_o;
    endproperty
    property p_idle_quiet;
        !busy_o |-> !mem_req_o && !host_pix_ready_o;
    endproperty
    property p_ready_hold;
        host_pix_ready_o && !host_pix_valid_i |=> host_pix_ready_o;
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy readback wrong");
    a_depth_mask: assert property (p_depth_mask) else $error("depth bit 7 set");
    a_align: assert property (p_align) else $error("base low bits set");
    a_high13: assert property (p_high13) else $error("unused high bits set");
    a_blend_mask: assert property (p_blend_mask) else $error("blend top bits set");
    a_rdata_drop: assert property (p_rdata_drop) else $error("read data held too long");
    a_req_hold: assert property (p_req_hold) else $error("memory request changed early");
    a_req_drop: assert property (p_req_drop) else $error("memory request kept after ack");
    a_idle_quiet: assert property (p_idle_quiet) else $error("activity while idle");
    a_ready_hold: assert property (p_ready_hold) else $error("host ready dropped");
endmodule : bte_setup_asserts
bind bte_setup bte_setup_asserts bte_setup_asserts_i (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .host_pix_valid_i(host_pix_valid_i),
    .host_pix_ready_o(host_pix_ready_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .busy_o(busy_o));

// >>> dv/bte_setup_tb_top.sv
`timescale 1ns/1ps
module bte_setup_tb_top;
    typedef struct { logic [7:0] a; logic [7:0] d; logic [7:0] e; } bte_row_type;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic reg_we_i = 1'b0, reg_re_i = 1'b0, host_pix_valid_i = 1'b0;
    logic [23:0] fg_color_i = 24'h123456, bg_color_i = 24'hABCDEF, host_pix_i = 24'h204080;
    logic host_pix_ready_o, mem_req_o, mem_we_o, mem_ack_i, busy_o;
    logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i, last_addr, last_data;
    logic [3:0] lat_q = 4'h0;
    logic [7:0] rd_byte_q = 8'h80;
    int n_wr, n_fail = 0, checks_done = 0, cyc = 0;
    bte_row_type rows [11] = '{'{8'h92, 8'hFF, 8'h7F}, '{8'h93, 8'hFF, 8'hFC}, '{8'h97, 8'hFF, 8'hFC},
        '{8'h98, 8'hFF, 8'h1F}, '{8'hB2, 8'hFF, 8'h1F}, '{8'hB5, 8'hFF, 8'h3F}, '{8'h96, 8'hA5, 8'hA5},
        '{8'h90, 8'hEE, 8'h00}, '{8'hB6, 8'hFF, 8'h00}, '{8'h8F, 8'hFF, 8'h00}, '{8'hA0, 8'h5A, 8'h5A}};
    // target 0x1000 width 4, window 2x1, source a 0x2000 width 8
    logic [7:0] setup [12][2] = '{'{8'h92, 8'h03}, '{8'hA7, 8'h00}, '{8'hA8, 8'h10}, '{8'hAB, 8'h04},
        '{8'hB1, 8'h02}, '{8'hB2, 8'h00}, '{8'hB3, 8'h01}, '{8'h93, 8'h00}, '{8'h94, 8'h20}, '{8'h96, 8'h00},
        '{8'h97, 8'h08}, '{8'h98, 8'h00}};
    logic [7:0] fac [4] = '{8'h10, 8'h2F, 8'h00, 8'h1F};
    logic [23:0] bexp [4] = '{24'h706060, 24'hC08040, 24'h204080, 24'hBB7E42};

    bte_setup bte_setup_i (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .fg_color_i(fg_color_i),
        .bg_color_i(bg_color_i), .host_pix_i(host_pix_i), .host_pix_valid_i(host_pix_valid_i),
        .host_pix_ready_o(host_pix_ready_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .busy_o(busy_o));
    bte_mem_model bte_mem_model_i (.mclk_i(mclk_i), .rst_i(rst_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
        .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i),
        .lat_i(lat_q), .rd_byte_i(rd_byte_q), .n_wr_o(n_wr), .last_addr_o(last_addr), .last_data_o(last_data));

    // ==================================================
    // clock, host stream stalls and timeout
    always #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc++;
        host_pix_valid_i <= cyc[1];
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    // ==================================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge mclk_i);
        reg_we_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge mclk_i);
        reg_re_i <= 1'b0;
        #1 chk("rdata", {24'h0, reg_rdata_o}, {24'h0, e});
    endtask : rd
    task automatic run(input logic [3:0] op, input int nw, input logic [31:0] ad, input logic [23:0] d);
        int n0;
        int k;
        n0 = n_wr;
        k = 0;
        wr(8'h91, {4'h0, op});
        wr(8'h90, 8'h10);
        if (nw > 0) rd(8'h90, 8'h10);
        repeat (2) @(negedge mclk_i);
        while (busy_o !== 1'b0 && k < 3000) begin
            @(negedge mclk_i);
            k++;
        end
        chk("busy", {31'h0, busy_o}, 32'h0);
        chk("writes", 32'(n_wr - n0), 32'(nw));
        if (nw > 0) begin
            chk("address", last_addr, ad);
            chk("pixel", {8'h0, last_data[23:0]}, {8'h0, d});
        end
        $display("test opcode %h done", op);
    endtask : run
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // ==================================================
    // main sequence
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (int a = 8'h90; a <= 8'hB5; a++) rd(8'(a), 8'h00);
        $display("test reset values done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        $display("test register table done");
        foreach (setup[i]) wr(setup[i][0], setup[i][1]);
        run(4'hC, 2, 32'h1003, fg_color_i);
        run(4'hD, 0, 32'h0, 24'h0);
        // constant colour source b, slow memory
        lat_q = 4'h6;
        wr(8'h92, 8'h0F);
        wr(8'h9D, 8'h40);
        wr(8'h9E, 8'h80);
        wr(8'h9F, 8'hC0);
        foreach (fac[i]) begin
            wr(8'hB5, fac[i]);
            run(4'hB, 2, 32'h1003, bexp[i]);
        end
        lat_q = 4'h1;
        wr(8'h92, 8'h03);
        run(4'hE, 2, 32'h1003, bg_color_i);
        run(4'hF, 1, 32'h1000, fg_color_i);
        print_verdict();
    end
endmodule : bte_setup_tb_top
